// *** include/tcap_defs.svh ***
`ifndef TCAP_DEFS_SVH
`define TCAP_DEFS_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define TCAP_IDX_PORT_DATA   6'h00
`define TCAP_IDX_PORT_DIR    6'h01
`define TCAP_IDX_COUNT_HI    6'h0e
`define TCAP_IDX_COUNT_LO    6'h0f
`define TCAP_IDX_CAP1_HI     6'h10
`define TCAP_IDX_CAP1_LO     6'h11
`define TCAP_IDX_CAP2_HI     6'h12
`define TCAP_IDX_CAP2_LO     6'h13
`define TCAP_IDX_CAP3_HI     6'h14
`define TCAP_IDX_CAP3_LO     6'h15
`define TCAP_IDX_SHARED_HI   6'h1e
`define TCAP_IDX_SHARED_LO   6'h1f
`define TCAP_IDX_EDGE_CTRL   6'h21
`define TCAP_IDX_MASK        6'h22
`define TCAP_IDX_FLAG        6'h23
`define TCAP_IDX_PACC_CTRL   6'h26

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TCAP_CAP4_SEL_BIT    2
`define TCAP_OVF_FLAG_BIT    7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TCAP_EDGE_RESET      8'h00
`define TCAP_DIR_RESET       8'h00
`define TCAP_DATA_RESET      8'h00
`define TCAP_PACC_RESET      8'h00
`define TCAP_MASK_RESET      8'h00
`define TCAP_FLAG_RESET      8'h00
`define TCAP_COUNT_RESET     16'h0000
`define TCAP_COUNT_MAX       16'hffff
`define TCAP_SHARED_RESET    16'hffff

`endif

// *** include/tcap_pkg.sv ***
package tcap_pkg;

    // ---------------------------------------------------------------
    // bus request and edge field types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tcap_wb_req_type;

    typedef enum logic [1:0] {
        EDGE_OFF,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_ANY
    } tcap_edge_type;

endpackage

// *** core/tcap_top.sv ***
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "tcap_defs.svh"
// Operation
// - edge detect and select on port bits 3:0
// - port bits 3:0 always readable
// - compare-owned pins ignore software data
// - compare channel one may own bits 7:3
// - bit 7 gpio, accumulator input, or compare
// - selected edge latches free-running counter
// - edges synchronised; latch stable counter value
// - bit 3 captures only when select set
// - direction bit clears; driven writes cause captures
// - shared register ignores writes as capture
// - edge field: off, rise, fall, any
// - edge control at 0x21, reset zero
// - channels independent, may share counts
// - capture is one 16-bit parallel transfer
// - capture bytes read-only, writes ignored
// - high-byte read delays capture one cycle
// - dedicated capture pairs untouched by reset
// - capture pairs mapped 0x10 to 0x15
// - counter wraps at 0xffff, sets overflow
module tcap_top #(
    parameter int CNT_DIV = 1
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire tcap_pkg::tcap_wb_req_type wb_req_i,
    output logic                        wb_ack_o,
    output logic [31:0]                 wb_dat_o,
    input  wire logic [7:0]             port_pin_i,
    output logic [7:0]                  port_pin_o,
    output logic [7:0]                  port_pin_oe_n_o,
    input  wire logic [4:0]             compare_own_i,
    input  wire logic [4:0]             compare_level_i,
    output logic [15:0]                 shared_capture4_compare5_reg_o,
    output logic                        capture4_select_o,
    output logic [15:0]                 free_running_counter_o,
    output logic                        pulse_accum_input_o,
    output logic                        capture_irq_o
);
    import tcap_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] field,
                                      input logic rise, input logic fall);
        tcap_edge_type mode;
        mode = tcap_edge_type'(field);
        unique case (mode)
            EDGE_OFF:  edge_hit = 1'b0;
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_ANY:  edge_hit = rise | fall;
        endcase
    endfunction

    // high-byte index of each channel: cap1, cap2, cap3, shared
    function automatic logic [5:0] hi_index(input int ch);
        unique case (ch)
            0:       hi_index = `TCAP_IDX_CAP1_HI;
            1:       hi_index = `TCAP_IDX_CAP2_HI;
            2:       hi_index = `TCAP_IDX_CAP3_HI;
            default: hi_index = `TCAP_IDX_SHARED_HI;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // registers and state
    // ---------------------------------------------------------------
    logic [7:0]  edge_ctrl;
    logic [7:0]  port_data;
    logic [7:0]  port_dir;
    logic [7:0]  pacc_ctrl;
    logic [7:0]  irq_mask;
    logic [7:0]  irq_flag;
    logic [15:0] count;
    logic [7:0]  div_cnt;
    logic        count_tick;
    logic [15:0] cap_val [0:3];
    logic [3:0]  cap_pending;
    logic [3:0]  cap_block;
    logic [3:0]  cap_done;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  sync3;
    logic [7:0]  pin_level;
    logic [7:0]  pin_rise;
    logic [7:0]  pin_fall;
    logic [7:0]  next_flag;
    logic [31:0] next_dat;

    wire logic [5:0] bus_idx  = wb_req_i.adr[7:2];
    wire logic       bus_req  = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
    wire logic       bus_wr   = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we
                                & wb_ack_o & wb_req_i.sel[0];
    wire logic [7:0] wr_byte  = wb_req_i.dat[7:0];
    wire logic       cap4_sel = pacc_ctrl[`TCAP_CAP4_SEL_BIT];

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // a level counts once stages two and three agree; stage one feeds
    // stage two only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            sync3 <= 8'h00;
        end else begin
            sync1 <= port_pin_i;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    generate
        for (genvar b = 0; b < 8; b++) begin : g_pin
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_level[b] <= 1'b0;
                    pin_rise[b]  <= 1'b0;
                    pin_fall[b]  <= 1'b0;
                end else begin
                    pin_rise[b] <= 1'b0;
                    pin_fall[b] <= 1'b0;
                    if (sync2[b] == sync3[b] && sync3[b] != pin_level[b]) begin
                        pin_level[b] <= sync3[b];
                        pin_rise[b]  <= sync3[b];
                        pin_fall[b]  <= ~sync3[b];
                    end
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // free-running counter
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt    <= 8'h00;
            count_tick <= 1'b0;
        end else if (div_cnt == 8'(CNT_DIV - 1)) begin
            div_cnt    <= 8'h00;
            count_tick <= 1'b1;
        end else begin
            div_cnt    <= div_cnt + 8'h01;
            count_tick <= 1'b0;
        end
    end

    // the count moves only on this edge, so a capture sees a settled value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= `TCAP_COUNT_RESET;
        end else if (count_tick) begin
            count <= count + 16'h0001;
        end
    end

    // ---------------------------------------------------------------
    // capture channels
    // ---------------------------------------------------------------
    // channel 0..3 = capture one..four on pins 2, 1, 0, 3
    localparam int PIN_OF [0:3] = '{2, 1, 0, 3};
    localparam int FLD_OF [0:3] = '{4, 2, 0, 6};

    generate
        for (genvar ch = 0; ch < 4; ch++) begin : g_cap
            localparam int P = PIN_OF[ch];
            localparam int F = FLD_OF[ch];
            logic armed;
            logic hit;
            logic shared_wr_hi;
            logic shared_wr_lo;
            assign armed = (ch == 3) ? cap4_sel : 1'b1;
            assign hit   = armed & edge_hit(edge_ctrl[F+1:F],
                                            pin_rise[P], pin_fall[P]);
            assign shared_wr_hi = (ch == 3) & ~cap4_sel & bus_wr
                                  & (bus_idx == `TCAP_IDX_SHARED_HI);
            assign shared_wr_lo = (ch == 3) & ~cap4_sel & bus_wr
                                  & (bus_idx == `TCAP_IDX_SHARED_LO);

            // a high-byte read holds the pair for one cycle only
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cap_block[ch] <= 1'b0;
                end else begin
                    cap_block[ch] <= bus_req & ~wb_req_i.we
                                     & (bus_idx == hi_index(ch));
                end
            end

            // an edge during a blocked cycle waits, it is never dropped
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cap_pending[ch] <= 1'b0;
                    cap_done[ch]    <= 1'b0;
                end else begin
                    cap_done[ch] <= (hit | cap_pending[ch]) & ~cap_block[ch];
                    if (cap_block[ch]) begin
                        cap_pending[ch] <= cap_pending[ch] | hit;
                    end else begin
                        cap_pending[ch] <= 1'b0;
                    end
                end
            end

            if (ch == 3) begin : g_shared
                always_ff @(posedge clk_i) begin
                    if (rst_i) begin
                        cap_val[ch] <= `TCAP_SHARED_RESET;
                    end else if ((hit | cap_pending[ch]) & ~cap_block[ch]) begin
                        cap_val[ch] <= count;
                    end else if (shared_wr_hi) begin
                        cap_val[ch][15:8] <= wr_byte;
                    end else if (shared_wr_lo) begin
                        cap_val[ch][7:0] <= wr_byte;
                    end
                end
            end else begin : g_dedicated
                // no reset branch: the pair keeps its value through reset
                always_ff @(posedge clk_i) begin
                    if (!rst_i && (hit | cap_pending[ch]) && !cap_block[ch]) begin
                        cap_val[ch] <= count;
                    end
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_ctrl <= `TCAP_EDGE_RESET;
        end else if (bus_wr && bus_idx == `TCAP_IDX_EDGE_CTRL) begin
            edge_ctrl <= wr_byte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_data <= `TCAP_DATA_RESET;
            port_dir  <= `TCAP_DIR_RESET;
        end else if (bus_wr && bus_idx == `TCAP_IDX_PORT_DATA) begin
            port_data <= wr_byte;
        end else if (bus_wr && bus_idx == `TCAP_IDX_PORT_DIR) begin
            port_dir <= wr_byte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pacc_ctrl <= `TCAP_PACC_RESET;
            irq_mask  <= `TCAP_MASK_RESET;
        end else if (bus_wr && bus_idx == `TCAP_IDX_PACC_CTRL) begin
            pacc_ctrl <= wr_byte;
        end else if (bus_wr && bus_idx == `TCAP_IDX_MASK) begin
            irq_mask <= wr_byte;
        end
    end

    // flags clear by writing ones; a set in the same cycle wins
    always_comb begin
        next_flag = irq_flag;
        if (bus_wr && bus_idx == `TCAP_IDX_FLAG) begin
            next_flag = next_flag & ~wr_byte;
        end
        next_flag[3:0] = next_flag[3:0] | cap_done;
        if (count_tick && count == `TCAP_COUNT_MAX) begin
            next_flag[`TCAP_OVF_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_flag      <= `TCAP_FLAG_RESET;
            capture_irq_o <= 1'b0;
        end else begin
            irq_flag      <= next_flag;
            capture_irq_o <= |(next_flag & irq_mask);
        end
    end

    // ---------------------------------------------------------------
    // bus read path
    // ---------------------------------------------------------------
    always_comb begin
        next_dat = 32'h0000_0000;
        unique case (bus_idx)
            `TCAP_IDX_PORT_DATA: next_dat[7:0] = pin_level;
            `TCAP_IDX_PORT_DIR:  next_dat[7:0] = port_dir;
            `TCAP_IDX_COUNT_HI:  next_dat[7:0] = count[15:8];
            `TCAP_IDX_COUNT_LO:  next_dat[7:0] = count[7:0];
            `TCAP_IDX_CAP1_HI:   next_dat[7:0] = cap_val[0][15:8];
            `TCAP_IDX_CAP1_LO:   next_dat[7:0] = cap_val[0][7:0];
            `TCAP_IDX_CAP2_HI:   next_dat[7:0] = cap_val[1][15:8];
            `TCAP_IDX_CAP2_LO:   next_dat[7:0] = cap_val[1][7:0];
            `TCAP_IDX_CAP3_HI:   next_dat[7:0] = cap_val[2][15:8];
            `TCAP_IDX_CAP3_LO:   next_dat[7:0] = cap_val[2][7:0];
            `TCAP_IDX_SHARED_HI: next_dat[7:0] = cap_val[3][15:8];
            `TCAP_IDX_SHARED_LO: next_dat[7:0] = cap_val[3][7:0];
            `TCAP_IDX_EDGE_CTRL: next_dat[7:0] = edge_ctrl;
            `TCAP_IDX_MASK:      next_dat[7:0] = irq_mask;
            `TCAP_IDX_FLAG:      next_dat[7:0] = irq_flag;
            `TCAP_IDX_PACC_CTRL: next_dat[7:0] = pacc_ctrl;
            default:             next_dat = 32'h0000_0000;
        endcase
    end

    // one wait state: ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= next_dat;
            end
        end
    end

    // ---------------------------------------------------------------
    // port pin drive
    // ---------------------------------------------------------------
    // bits 2:0 are input only; bits 7:3 are gpio or compare outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_pin_o      <= 8'h00;
            port_pin_oe_n_o <= 8'hff;
        end else begin
            port_pin_o[2:0]      <= 3'h0;
            port_pin_oe_n_o[2:0] <= 3'h7;
            for (int b = 3; b < 8; b++) begin
                // capture four takes bit 3 away from compare logic
                if (compare_own_i[b-3] && !(b == 3 && cap4_sel)) begin
                    port_pin_o[b]      <= compare_level_i[b-3];
                    port_pin_oe_n_o[b] <= 1'b0;
                end else begin
                    port_pin_o[b]      <= port_data[b];
                    port_pin_oe_n_o[b] <= ~port_dir[b];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // status outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shared_capture4_compare5_reg_o <= `TCAP_SHARED_RESET;
            capture4_select_o              <= 1'b0;
            free_running_counter_o         <= `TCAP_COUNT_RESET;
            pulse_accum_input_o            <= 1'b0;
        end else begin
            shared_capture4_compare5_reg_o <= cap_val[3];
            capture4_select_o              <= cap4_sel;
            free_running_counter_o         <= count;
            pulse_accum_input_o            <= pin_level[7];
        end
    end

endmodule // tcap_top

// *** verification/tcap_top_props.sv ***
`timescale 1ns/1ps
module tcap_top_chk #(
    parameter int CNT_DIV = 1
) (
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire tcap_pkg::tcap_wb_req_type wb_req_i,
    input wire logic                      wb_ack_o,
    input wire logic [31:0]               wb_dat_o,
    input wire logic [7:0]                port_pin_i,
    input wire logic [7:0]                port_pin_o,
    input wire logic [7:0]                port_pin_oe_n_o,
    input wire logic [4:0]                compare_own_i,
    input wire logic [4:0]                compare_level_i,
    input wire logic [15:0]               shared_capture4_compare5_reg_o,
    input wire logic                      capture4_select_o,
    input wire logic [15:0]               free_running_counter_o,
    input wire logic                      pulse_accum_input_o,
    input wire logic                      capture_irq_o
);
    import tcap_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ---------------------------------------------------------------
    // sequences
    // ---------------------------------------------------------------
    sequence s_taken;
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    endsequence
    // the counter output lags, so give reset a few edges to drain
    sequence s_settled;
        !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3) && !$past(rst_i, 4);
    endsequence
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_ack_after_take: assert property (s_taken |=> wb_ack_o)
        else $error("bus request not acknowledged one cycle later");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge lasted more than one cycle");
    a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_req_i.cyc && wb_req_i.stb))
        else $error("acknowledge without a request");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_counter_steps: assert property (
        ((CNT_DIV == 1) and s_settled) |->
        free_running_counter_o == $past(free_running_counter_o) + 16'h0001)
        else $error("counter did not advance by one");
    a_low_pins_input: assert property (port_pin_oe_n_o[2:0] == 3'b111)
        else $error("capture-only pin driven");
    for (genvar j = 1; j < 5; j++) begin : g_own
        a_compare_owns_pin: assert property (
            !$past(rst_i) && $past(compare_own_i[j]) |->
            !port_pin_oe_n_o[j+3] && port_pin_o[j+3] == $past(compare_level_i[j]))
            else $error("compare-owned pin not driven with compare level");
    end
    a_pin3_compare: assert property (
        !capture4_select_o && !$past(capture4_select_o) && !$past(rst_i)
        && $past(compare_own_i[0]) |->
        !port_pin_oe_n_o[3] && port_pin_o[3] == $past(compare_level_i[0]))
        else $error("bit 3 not driven by compare while capture four is off");
    a_accum_follows: assert property (
        $stable(port_pin_i[7]) [*6] |-> pulse_accum_input_o == port_pin_i[7])
        else $error("accumulator input does not follow pin 7");
endmodule // tcap_top_chk

bind tcap_top tcap_top_chk #(.CNT_DIV(CNT_DIV)) i_chk (.*);

// *** verification/tcap_pin_partner.sv ***
`timescale 1ns/1ps
module tcap_pin_partner (
    input  wire logic       clk_i,
    input  wire logic [7:0] want_i,
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] oe_n_i,
    output logic [7:0]      pin_level_o
);
    // ---------------------------------------------------------------
    // external event source
    // ---------------------------------------------------------------
    logic [7:0] ext = 8'h00;
    always @(posedge clk_i) begin
        ext <= want_i;
    end
    // no pulls: the source drives a pin only while the device has let go of it
    assign pin_level_o = (oe_n_i & ext) | (~oe_n_i & pin_o_i);
endmodule // tcap_pin_partner

// *** verification/tcap_top_tb_top.sv ***
`timescale 1ns/1ps
`include "tcap_defs.svh"
module tcap_top_tb_top;
    import tcap_pkg::*;
    typedef struct packed {logic [7:0] exp; logic [7:0] msk;} tcap_note_type;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    tcap_wb_req_type wb_req = '0;
    logic wb_ack, sel4, pacc, irq;
    logic [31:0] wb_dat;
    logic [7:0] pin_lvl, pin_o, oe_n, rnd;
    logic [7:0] want = 8'h00;
    logic [4:0] c_own = 5'h00;
    logic [4:0] c_lvl = 5'h00;
    logic [15:0] shared, cnt, v, v2;
    // pin to latch takes six edges after drive, and the count trails cyc_cnt by one
    int fails = 0, checks = 0, cyc_cnt = 0, tmo = 0, lat = 5, t;
    tcap_note_type q[$], n;
    tcap_top #(.CNT_DIV(1)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
        .wb_ack_o(wb_ack), .wb_dat_o(wb_dat), .port_pin_i(pin_lvl), .port_pin_o(pin_o),
        .port_pin_oe_n_o(oe_n), .compare_own_i(c_own), .compare_level_i(c_lvl),
        .shared_capture4_compare5_reg_o(shared), .capture4_select_o(sel4),
        .free_running_counter_o(cnt), .pulse_accum_input_o(pacc), .capture_irq_o(irq));
    tcap_pin_partner i_pins (.clk_i(clk_i), .want_i(want), .pin_o_i(pin_o), .oe_n_i(oe_n),
        .pin_level_o(pin_lvl));
    always #12.5 clk_i = ~clk_i;
    // ---------------------------------------------------------------
    // checking and closing
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (q.size() != 0) fails++;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt <= rst_i ? 0 : cyc_cnt + 1;
        tmo <= tmo + 1;
        if (wb_ack === 1'b1 && wb_req.we === 1'b0 && q.size() > 0) begin
            n = q.pop_front();
            chk("read data", 16'(wb_dat[7:0] & n.msk), 16'(n.exp & n.msk));
        end
        if (tmo == 20000) begin
            fails++;
            conclude();
        end
    end
    // ---------------------------------------------------------------
    // bus and pin tasks
    // ---------------------------------------------------------------
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      input logic [7:0] e, input logic [7:0] m, output logic [7:0] rv);
        if (!w) q.push_back({e, m});
        @(posedge clk_i);
        wb_req <= {1'b1, 1'b1, w, idx, 2'b00, 4'hf, 24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        rv = wb_dat[7:0];
        wb_req <= '0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] x;
        wb(1'b1, idx, d, 8'h00, 8'h00, x);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] x;
        wb(1'b0, idx, 8'h00, e, m, x);
    endtask
    // high byte first, then low byte at once: the coherent order
    task automatic rd_pair(input logic [5:0] idx, input logic [15:0] e, input logic [15:0] m,
                           output logic [15:0] rv);
        wb(1'b0, idx, 8'h00, e[15:8], m[15:8], rv[15:8]);
        wb(1'b0, 6'(idx + 6'h01), 8'h00, e[7:0], m[7:0], rv[7:0]);
    endtask
    task automatic drive(input logic [7:0] m, input logic lv, output int tt);
        @(posedge clk_i);
        want <= (want & ~m) | (m & {8{lv}});
        tt = cyc_cnt;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic cap(input int c, input logic [1:0] f);
        logic [15:0] a, b;
        logic [5:0] ci;
        int tt;
        ci = 6'(`TCAP_IDX_CAP1_HI + 2 * c);
        wr(`TCAP_IDX_EDGE_CTRL, 8'({f, 4'h0}) >> (2 * c));
        wr(`TCAP_IDX_FLAG, 8'hff);
        rd_pair(ci, 16'h0000, 16'h0000, a);
        drive(8'h04 >> c, 1'b1, tt);
        tick(12);
        rd(`TCAP_IDX_PORT_DATA, want, 8'h0f);
        rd_pair(ci, f[0] ? 16'(tt + lat) : a, 16'hffff, b);
        drive(8'h04 >> c, 1'b0, tt);
        tick(12);
        rd_pair(ci, f[1] ? 16'(tt + lat) : b, 16'hffff, a);
        rd(`TCAP_IDX_FLAG, 8'(|f) << c, 8'h01 << c);
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'ha2d8bbf4));
        tick(8);
        rst_i <= 1'b0;
        c_own <= 5'($urandom) & 5'h1e;
        c_lvl <= 5'($urandom);
        rd(`TCAP_IDX_EDGE_CTRL, 8'h00, 8'hff);
        rnd = 8'($urandom);
        wr(`TCAP_IDX_EDGE_CTRL, rnd);
        rd(`TCAP_IDX_EDGE_CTRL, rnd, 8'hff);
        wr(6'h3f, rnd);
        rd(6'h3f, 8'h00, 8'hff);
        for (int c = 0; c < 3; c++) begin
            for (int f = 0; f < 4; f++) begin
                cap(c, 2'(f));
            end
        end
        rd_pair(`TCAP_IDX_CAP1_HI, 16'h0000, 16'h0000, v);
        wr(`TCAP_IDX_CAP1_HI, ~v[15:8]);
        wr(`TCAP_IDX_CAP1_LO, ~v[7:0]);
        rd_pair(`TCAP_IDX_CAP1_HI, v, 16'hffff, v2);
        wr(`TCAP_IDX_EDGE_CTRL, 8'h14);
        drive(8'h06, 1'b1, t);
        tick(12);
        rd_pair(`TCAP_IDX_CAP1_HI, 16'(t + lat), 16'hffff, v);
        rd_pair(`TCAP_IDX_CAP2_HI, 16'(t + lat), 16'hffff, v);
        drive(8'h06, 1'b0, t);
        wr(`TCAP_IDX_EDGE_CTRL, 8'h10);
        for (int d = 0; d < 6; d++) begin
            drive(8'h04, 1'b1, t);
            tick(d);
            rd(`TCAP_IDX_CAP1_HI, 8'h00, 8'h00);
            tick(12);
            rd_pair(`TCAP_IDX_CAP1_HI, 16'h0000, 16'h0000, v);
            chk("delayed capture", v, 16'(t + lat + ((d == 3) ? 1 : 0)));
            drive(8'h04, 1'b0, t);
            tick(6);
        end
        wr(`TCAP_IDX_MASK, 8'h01);
        tick(2);
        chk("irq raised", 16'(irq), 16'h0001);
        wr(`TCAP_IDX_FLAG, 8'h01);
        tick(2);
        chk("irq cleared", 16'(irq), 16'h0000);
        wr(`TCAP_IDX_EDGE_CTRL, 8'hc0);
        wr(`TCAP_IDX_PORT_DIR, 8'h08);
        wr(`TCAP_IDX_PORT_DATA, 8'h08);
        tick(10);
        rd_pair(`TCAP_IDX_SHARED_HI, 16'hffff, 16'hffff, v);
        wr(`TCAP_IDX_PACC_CTRL, 8'h04);
        wr(`TCAP_IDX_PORT_DATA, 8'h00);
        tick(12);
        rd_pair(`TCAP_IDX_SHARED_HI, 16'h0000, 16'h0000, v);
        chk("fourth capture", 16'(v != 16'hffff), 16'h0001);
        wr(`TCAP_IDX_SHARED_HI, ~v[15:8]);
        wr(`TCAP_IDX_SHARED_LO, ~v[7:0]);
        rd_pair(`TCAP_IDX_SHARED_HI, v, 16'hffff, v2);
        chk("shared output", shared, v);
        chk("select output", 16'(sel4), 16'h0001);
        wr(`TCAP_IDX_PACC_CTRL, 8'h00);
        c_own <= 5'h1f;
        tick(6);
        rd_pair(`TCAP_IDX_CAP1_HI, 16'h0000, 16'h0000, v);
        rst_i <= 1'b1;
        tick(8);
        rst_i <= 1'b0;
        rd_pair(`TCAP_IDX_CAP1_HI, v, 16'hffff, v2);
        rd(`TCAP_IDX_EDGE_CTRL, 8'h00, 8'hff);
        rd(`TCAP_IDX_PORT_DIR, 8'h00, 8'h08);
        tick(2);
        conclude();
    end
endmodule // tcap_top_tb_top
